// file: verilog/pdb_bank.sv
// peripheral disable register bank with per-function gating outputs
//
// Overview of operation
// [R1] bit 7 of sys_and_misc_disable set stops peripheral system clock distribution.
// [R2] only functions fed by the gated system clock see that gate; others run on.
// [R3] bit 6 of sys_and_misc_disable set turns the fixed voltage reference off.
// [R4] bit 2 of sys_and_misc_disable set blocks all data nonvolatile memory reads and writes.
// [R5] while nvmem_off is set, nvmem control register writes are ignored.
// [R6] while nvmem_off is set, indirect pointer reads of nonvolatile memory return zero.
// [R7] software waits up to 1 us after clearing nvmem_off before touching memory data.
// [R8] bit 1 of sys_and_misc_disable set turns the reference clock output off.
// [R9] bit 0 of sys_and_misc_disable set turns pin-change interrupts of all ports off.
// [R10] bits 5 to 3 of sys_and_misc_disable ignore writes and read as zero.
// [R11] all implemented bits are read/write and clear to zero on any reset.
// [R12] bits 6 to 0 of timer_osc_disable each turn off the timer of the same index.
// [R13] a disabled function is frozen, held in reset, ignores writes, reads 0x00, outputs 0.
// [R14] a re-enabled function restarts from its reset state.
// [R15] software leaves a function alone for one instruction cycle after enabling it.
// [R16] bit 7 of timer_osc_disable set turns the numerically controlled oscillator off.
// [R17] a disable bit change reaches the gating outputs two clock edges after the write.
`timescale 1ns/100ps
`default_nettype none

module pdb_bank
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [pdb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pdb_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pdb_pkg::DATA_W-1:0] o_rdata,
  output logic o_periph_sysclk_off,
  output logic o_vref_off,
  output logic o_nvmem_off,
  output logic o_refclk_out_off,
  output logic o_pin_change_irq_off,
  output logic o_numeric_osc_off,
  output logic [pdb_pkg::NUM_TIMERS-1:0] o_timer_off,
  output logic o_nvmem_ready
);

  pdb_pkg::pdb_state_t state;
  pdb_pkg::pdb_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.rdata = pdb_pkg::READ_ZERO;
    if (i_wr)
    begin
      // [R10] mask unimplemented bits
      if (i_addr == pdb_pkg::SYS_MISC_OFF)
        next_state.sys_and_misc_disable = i_wdata & pdb_pkg::SYS_MISC_MASK;
      // [R11] read/write bits
      if (i_addr == pdb_pkg::TMR_OSC_OFF)
        next_state.timer_osc_disable = i_wdata & pdb_pkg::TMR_OSC_MASK;
    end
    if (i_rd)
    begin
      if (i_addr == pdb_pkg::SYS_MISC_OFF)
        next_state.rdata = state.sys_and_misc_disable;
      else if (i_addr == pdb_pkg::TMR_OSC_OFF)
        next_state.rdata = state.timer_osc_disable;
    end
    // [R1] [R2] sysclk gate output
    next_state.periph_sysclk_off = state.sys_and_misc_disable[pdb_pkg::BIT_SYSCLK];
    // [R3] vref gate
    next_state.vref_off = state.sys_and_misc_disable[pdb_pkg::BIT_VREF];
    // [R4] [R5] [R6] nvmem block
    next_state.nvmem_off = state.sys_and_misc_disable[pdb_pkg::BIT_NVMEM];
    // [R8] refclk gate
    next_state.refclk_out_off = state.sys_and_misc_disable[pdb_pkg::BIT_REFCLK];
    // [R9] pin-change gate
    next_state.pin_change_irq_off = state.sys_and_misc_disable[pdb_pkg::BIT_PINCHG];
    // [R16] oscillator gate
    next_state.numeric_osc_off = state.timer_osc_disable[pdb_pkg::BIT_NCO];
    // [R12] timer gates
    next_state.timer_off = state.timer_osc_disable[pdb_pkg::NUM_TIMERS-1:0];
    // [R7] [R14] nvmem wake delay after enable
    if (state.sys_and_misc_disable[pdb_pkg::BIT_NVMEM])
    begin
      next_state.nvmem_wake_cnt = '0;
      next_state.nvmem_ready = 1'b0;
    end
    else if (state.nvmem_wake_cnt != pdb_pkg::WAKE_W'(pdb_pkg::NVM_WAKE_CYC))
    begin
      next_state.nvmem_wake_cnt = state.nvmem_wake_cnt + 1'b1;
      next_state.nvmem_ready = 1'b0;
    end
    else
      next_state.nvmem_ready = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    // [R11] clear disable bits on reset; preload wake count and set nvmem ready
    if (i_rst)
    begin
      state <= '0;
      state.sys_and_misc_disable <= pdb_pkg::RESET_VAL;
      state.timer_osc_disable <= pdb_pkg::RESET_VAL;
      state.nvmem_wake_cnt <= pdb_pkg::WAKE_W'(pdb_pkg::NVM_WAKE_CYC);
      state.nvmem_ready <= 1'b1;
    end
    else
      state <= next_state;
  end

  // [R13] [R17] outputs from flip-flops
  assign o_rdata = state.rdata;
  assign o_periph_sysclk_off = state.periph_sysclk_off;
  assign o_vref_off = state.vref_off;
  assign o_nvmem_off = state.nvmem_off;
  assign o_refclk_out_off = state.refclk_out_off;
  assign o_pin_change_irq_off = state.pin_change_irq_off;
  assign o_numeric_osc_off = state.numeric_osc_off;
  assign o_timer_off = state.timer_off;
  assign o_nvmem_ready = state.nvmem_ready;

endmodule // pdb_bank

`default_nettype wire

// file: pkg/pdb_pkg.sv
// constants and state type for the peripheral disable bank
package pdb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] SYS_MISC_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] TMR_OSC_OFF = 4'h1;
  localparam logic [DATA_W-1:0] RESET_VAL = 8'h00;
  localparam logic [DATA_W-1:0] SYS_MISC_MASK = 8'hc7;
  localparam logic [DATA_W-1:0] TMR_OSC_MASK = 8'hff;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam int BIT_SYSCLK = 7;
  localparam int BIT_VREF = 6;
  localparam int BIT_NVMEM = 2;
  localparam int BIT_REFCLK = 1;
  localparam int BIT_PINCHG = 0;
  localparam int BIT_NCO = 7;
  localparam int NUM_TIMERS = 7;
  localparam int CLK_MHZ = 20;
  localparam int NVM_WAKE_NS = 1000;
  localparam int NVM_WAKE_CYC = (NVM_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_W = 8;

  typedef struct packed {
    logic [DATA_W-1:0] sys_and_misc_disable;
    logic [DATA_W-1:0] timer_osc_disable;
    logic [DATA_W-1:0] rdata;
    logic periph_sysclk_off;
    logic vref_off;
    logic nvmem_off;
    logic refclk_out_off;
    logic pin_change_irq_off;
    logic numeric_osc_off;
    logic [NUM_TIMERS-1:0] timer_off;
    logic [WAKE_W-1:0] nvmem_wake_cnt;
    logic nvmem_ready;
  } pdb_state_t;
endpackage

// file: dv/pdb_bank_sva.sv
// port checker for the peripheral disable bank
`timescale 1ns/100ps
`default_nettype none
module pdb_bank_sva
(
  input wire logic i_clk, i_rst, i_wr, i_rd, o_periph_sysclk_off, o_vref_off, o_nvmem_off,
  input wire logic o_refclk_out_off, o_pin_change_irq_off, o_numeric_osc_off, o_nvmem_ready,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic [6:0] o_timer_off
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  a_rd_unmapped: assert property ($past(i_rd && i_addr > 4'h1) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_reserved: assert property ($past(i_rd && i_addr == 4'h0) |-> o_rdata[5:3] == 3'h0)
    else $error("reserved bits not zero");
  a_sys_gates: assert property ($past(i_wr && i_addr == 4'h0, 2) |->
    {o_periph_sysclk_off, o_vref_off, o_nvmem_off, o_refclk_out_off, o_pin_change_irq_off}
    == {$past(i_wdata[7:6], 2), $past(i_wdata[2:0], 2)}) else $error("misc gate mismatch");
  a_tmr_gates: assert property ($past(i_wr && i_addr == 4'h1, 2) |->
    {o_numeric_osc_off, o_timer_off} == $past(i_wdata, 2))
    else $error("timer gate mismatch");
  a_nvm_block: assert property (o_nvmem_off |-> !o_nvmem_ready)
    else $error("nvmem ready while off");
  a_nvm_wake: assert property ($fell(o_nvmem_off) && !$past(i_rst) |->
    !o_nvmem_ready [*8] ##[1:30] o_nvmem_ready)
    else $error("nvmem wake timing");
  a_nvm_span: assert property ($fell(o_nvmem_off) && !$past(i_rst) |->
    ##19 !o_nvmem_ready ##1 o_nvmem_ready)
    else $error("nvmem wake span");
  a_rst_clear: assert property ($past(i_rst) |-> o_nvmem_ready &&
    {o_periph_sysclk_off, o_vref_off, o_nvmem_off, o_refclk_out_off, o_pin_change_irq_off,
    o_numeric_osc_off, o_timer_off, o_rdata} == 20'h0)
    else $error("gates not cleared by reset");
endmodule // pdb_bank_sva
bind pdb_bank pdb_bank_sva u_pdb_bank_sva (.*);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the peripheral disable bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, s, v, n, r, p, c, y;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic [6:0] t;
  int mismatches = 0, n_tests = 0;
  pdb_bank u_pdb_bank (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_periph_sysclk_off(s), .o_vref_off(v),
    .o_nvmem_off(n), .o_refclk_out_off(r), .o_pin_change_irq_off(p), .o_numeric_osc_off(c),
    .o_timer_off(t), .o_nvmem_ready(y));
  always #25 i_clk = ~i_clk;
  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic gt(input logic [7:0] e0, input logic [7:0] e1);
    repeat (2) @(posedge i_clk);
    #1 chk({s, v, 3'h0, n, r, p}, e0);
    chk({c, t}, e1);
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    chk({7'h0, y}, 8'h01);
    wr(4'h0, 8'hff);
    wr(4'h1, 8'hff);
    gt(8'hc7, 8'hff);
    rd(4'h0, 8'hc7);
    rd(4'h1, 8'hff);
    rd(4'h5, 8'h00);
    chk({7'h0, y}, 8'h00);
    wr(4'h0, 8'h00);
    repeat (10) @(posedge i_clk);
    #1 chk({7'h0, y}, 8'h00);
    repeat (30) @(posedge i_clk);
    #1 chk({7'h0, y}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h1, 8'h01 << i);
      gt(8'h00, 8'h01 << i);
    end
    wr(4'h0, 8'hff);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk({7'h0, y}, 8'h01);
    gt(8'h00, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    stop_test;
  end
  initial
  begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
